// file: crg_lp_map.vh
// Register map, field positions, reset values and timing counts of the low-power clock generator
`ifndef CRG_LP_MAP_VH
`define CRG_LP_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CRG_OFS_CTRL     4'h0
`define CRG_OFS_STATUS   4'h4
`define CRG_OFS_MASK     4'h8
`define CRG_OFS_RATE     4'hC

// ****************************************
// Control register fields
// ****************************************
`define CRG_CTL_CME      0
`define CRG_CTL_SELF_CLOCK_MODE_ENABLE     1
`define CRG_CTL_SELF_CLOCK_IRQ_ENABLE    2
`define CRG_CTL_PLL_CLOCK_SELECT   3
`define CRG_CTL_PCE      4
`define CRG_CTL_PRE      5
`define CRG_CTL_PSEUDO_STOP_SELECT     6
`define CRG_CTL_RESET    7'h03

// ****************************************
// Status fields (bits 0 to 2 sticky, write one to clear; bit 3 reads selfClockMode)
// ****************************************
`define CRG_ST_SELF_CLOCK_IRQ_FLAG     0
`define CRG_ST_RTIF      1
`define CRG_ST_QCOK      2
`define CRG_ST_W         3

// ****************************************
// Timing
// ****************************************
`define CRG_CHECK_NS     20000
`define CRG_CLK_NS       10
`define CRG_STEP_CYC     2'h2

`endif

// file: crg_rti_div.v
// Real-time interrupt divider: prescale table times count plus one
`timescale 1ns/1ps
`default_nettype none

module crg_rti_div (
    input  wire        clk_sys,   // System clock
    input  wire        resetn,    // Async reset, active low
    input  wire        runEn,     // Count enable (freeze when low)
    input  wire [6:0]  rateSel,   // Prescale and count select
    output reg         tick       // One-cycle divider pulse
);
    // ****************************************
    // Prescale table
    // ****************************************
    reg  [17:0] preLimit;         // Prescale minus one
    reg  [17:0] preCnt_q;         // Prescale counter
    reg  [3:0]  modCnt_q;         // Count-plus-one stage

    // Prescale choice by upper field
    always @* begin
        case (rateSel[6:4])
            3'h0:    preLimit = 18'h003E7;  // 1000
            3'h1:    preLimit = 18'h007CF;  // 2000
            3'h2:    preLimit = 18'h01387;  // 5000
            3'h3:    preLimit = 18'h0270F;  // 10000
            3'h4:    preLimit = 18'h04E1F;  // 20000
            3'h5:    preLimit = 18'h0C34F;  // 50000
            3'h6:    preLimit = 18'h1869F;  // 100000
            default: preLimit = 18'h30D3F;  // 200000
        endcase
    end

    // Counters hold while frozen, never reloaded
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            preCnt_q <= 18'h00000;
            modCnt_q <= 4'h0;
            tick     <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (runEn) begin
                if (preCnt_q >= preLimit) begin
                    preCnt_q <= 18'h00000;
                    if (modCnt_q >= rateSel[3:0]) begin
                        modCnt_q <= 4'h0;
                        tick     <= 1'b1;
                    end else begin
                        modCnt_q <= modCnt_q + 4'h1;
                    end
                end else begin
                    preCnt_q <= preCnt_q + 18'h00001;
                end
            end
        end
    end
endmodule // crg_rti_div

`default_nettype wire

// file: crg_lp_ctrl.v
// Low-power mode controller: wait and stop sequencing, clock monitor, self-clock, registers
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "crg_lp_map.vh"

module crg_lp_ctrl #(
    parameter CHECK_CYC = `CRG_CHECK_NS / `CRG_CLK_NS  // Clock quality window
) (
    input  wire        clk_sys,        // System clock
    input  wire        resetn,         // Async reset, active low
    input  wire        extResetReq,    // External reset request (pin)
    input  wire        watchdogExpire, // Watchdog timeout, same clock
    input  wire        oscClockLost,   // Clock monitor loss (pin)
    input  wire        oscClockGood,   // Oscillator seen good (pin)
    input  wire        waitReq,        // Core executes wait
    input  wire        stopReq,        // Core executes stop
    input  wire        irqPending,     // Any other interrupt pending
    input  wire        pllPowerDown,   // PLL deselected on wake from wait
    input  wire [3:0]  avs_address,    // Avalon byte address
    input  wire        avs_read,       // Avalon read
    input  wire        avs_write,      // Avalon write
    input  wire [31:0] avs_writedata,  // Avalon write data
    output reg  [31:0] avs_readdata,   // Avalon read data
    output reg         avs_waitrequest,// Avalon wait request
    output reg         irq,            // Level interrupt
    output reg         resetOut,       // Reset sequence active
    output reg  [1:0]  resetCause,     // 0 none 1 ext 2 wdog 3 monitor
    output reg         coreClkEn,      // Core clock gate
    output reg         sysClkEn,       // System clock gate
    output reg         pllEnable,      // PLL power
    output reg         oscEnable,      // Oscillator power
    output reg         vregLowPower,   // Regulator low-power request
    output reg         rtiClkEn,       // Timer clock gate
    output reg         watchdogClkEn,  // Watchdog clock gate
    output reg         selfClockMode,  // Running on self clock
    output reg         runMode         // Core in run mode
);
    // ****************************************
    // States (one-hot)
    // ****************************************
    localparam [6:0] ST_RUN   = 7'h01;  // Normal run
    localparam [6:0] ST_WAIT  = 7'h02;  // Wait mode
    localparam [6:0] ST_DSEL  = 7'h04;  // Stop: PLL deselected
    localparam [6:0] ST_PLLO  = 7'h08;  // Stop: PLL off
    localparam [6:0] ST_CORO  = 7'h10;  // Stop: core clock off
    localparam [6:0] ST_STOP  = 7'h20;  // Stop active
    localparam [6:0] ST_RST   = 7'h40;  // Reset sequence
    localparam [7:0] RST_LEN  = 8'h40;  // Reset sequence length

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg  [2:0]  extSync_q;    // External reset request
    reg  [2:0]  lostSync_q;   // Clock loss
    reg  [2:0]  goodSync_q;   // Clock good
    reg         extLvl_q;     // Accepted levels
    reg         lostLvl_q;
    reg         goodLvl_q;

    // Three stages; a change counts once the last two agree
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            extSync_q  <= 3'h0;
            lostSync_q <= 3'h0;
            goodSync_q <= 3'h0;
            extLvl_q   <= 1'b0;
            lostLvl_q  <= 1'b0;
            goodLvl_q  <= 1'b0;
        end else begin
            extSync_q  <= {extSync_q[1:0], extResetReq};
            lostSync_q <= {lostSync_q[1:0], oscClockLost};
            goodSync_q <= {goodSync_q[1:0], oscClockGood};
            if (extSync_q[1] == extSync_q[2])
                extLvl_q <= extSync_q[2];
            if (lostSync_q[1] == lostSync_q[2])
                lostLvl_q <= lostSync_q[2];
            if (goodSync_q[1] == goodSync_q[2])
                goodLvl_q <= goodSync_q[2];
        end
    end

    // ****************************************
    // Registers and state
    // ****************************************
    reg  [6:0]  state_q;          // Mode sequencer
    reg  [6:0]  ctrl_q;           // Control bits
    reg  [2:0]  status_q;         // Sticky events
    reg  [2:0]  mask_q;           // Interrupt mask
    reg  [6:0]  rate_q;           // Timer rate select
    reg  [7:0]  rstCnt_q;         // Reset sequence counter
    reg  [1:0]  stepCnt_q;        // Stop step spacing
    reg  [15:0] chkCnt_q;         // Clock quality window
    reg         chkBusy_q;        // Check in progress
    reg         lostPrev_q;       // Loss edge detect
    reg         pendRst_q;        // Unused, only cleared by reset
    wire        rtiTick;          // Divider pulse
    wire        accept;           // Bus access taken this cycle
    wire        lossEvt;          // New clock-monitor failure
    wire        chkPass;          // Clock check succeeded
    wire        inStop;           // Stop fully active
    wire        pseudo;           // Pseudo stop chosen
    wire [2:0]  stSet;            // Status set terms
    wire [2:0]  stClr;            // Status clear terms

    assign accept  = (avs_read | avs_write) & ~avs_waitrequest;
    assign lossEvt = lostLvl_q & ~lostPrev_q & ctrl_q[`CRG_CTL_CME];
    assign inStop  = (state_q == ST_STOP);
    assign pseudo  = ctrl_q[`CRG_CTL_PSEUDO_STOP_SELECT];
    // Full stop aborts the window, so no pass can arise there
    assign chkPass = chkBusy_q & goodLvl_q & (chkCnt_q == CHECK_CYC[15:0]) & ~(inStop & ~pseudo);
    assign stSet   = {chkPass, rtiTick, lossEvt & ctrl_q[`CRG_CTL_SELF_CLOCK_MODE_ENABLE]};
    assign stClr   = (accept & avs_write & avs_address == `CRG_OFS_STATUS) ? avs_writedata[2:0] : 3'h0;

    // ****************************************
    // Real-time interrupt divider
    // ****************************************
    crg_rti_div u_rti (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .runEn   (~inStop | (pseudo & ctrl_q[`CRG_CTL_PRE])),
        .rateSel (rate_q),
        .tick    (rtiTick)
    );

    // ****************************************
    // Bus slave: one wait cycle per access
    // ****************************************
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                case (avs_address)
                    `CRG_OFS_CTRL:   avs_readdata <= {25'h0, ctrl_q};
                    `CRG_OFS_STATUS: avs_readdata <= {28'h0, selfClockMode, status_q};
                    `CRG_OFS_MASK:   avs_readdata <= {29'h0, mask_q};
                    `CRG_OFS_RATE:   avs_readdata <= {25'h0, rate_q};
                    default:         avs_readdata <= 32'h00000000;  // Unmapped reads zero
                endcase
            end
        end
    end

    // ****************************************
    // Status, mask, rate and interrupt
    // ****************************************
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            status_q <= 3'h0;
            mask_q   <= 3'h0;
            rate_q   <= 7'h00;
            irq      <= 1'b0;
        end else if (state_q == ST_RST) begin
            // Configuration returns to defaults during the sequence
            status_q <= 3'h0;
            mask_q   <= 3'h0;
            rate_q   <= 7'h00;
            irq      <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            status_q <= (status_q & ~stClr) | stSet;
            if (accept & avs_write & avs_address == `CRG_OFS_MASK)
                mask_q <= avs_writedata[2:0];
            if (accept & avs_write & avs_address == `CRG_OFS_RATE)
                rate_q <= avs_writedata[6:0];
            irq <= |(((status_q & ~stClr) | stSet) & mask_q);
        end
    end

    // ****************************************
    // Clock quality checker
    // ****************************************
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chkCnt_q      <= 16'h0000;
            chkBusy_q     <= 1'b0;
            selfClockMode <= 1'b0;
            lostPrev_q    <= 1'b0;
        end else if (state_q == ST_RST) begin
            chkCnt_q      <= 16'h0000;
            chkBusy_q     <= 1'b0;
            selfClockMode <= 1'b0;
            lostPrev_q    <= lostLvl_q;
        end else begin
            lostPrev_q <= lostLvl_q;
            if (lossEvt & ctrl_q[`CRG_CTL_SELF_CLOCK_MODE_ENABLE]) begin
                selfClockMode <= 1'b1;
                chkBusy_q     <= 1'b1;
                chkCnt_q      <= 16'h0000;
            end else if (chkBusy_q & inStop & ~pseudo) begin
                chkCnt_q <= 16'h0000;
            end else if (chkPass) begin
                chkBusy_q     <= 1'b0;
                selfClockMode <= 1'b0;
            end else if (chkBusy_q) begin
                // Keeps going through wait and pseudo stop
                if (chkCnt_q == CHECK_CYC[15:0])
                    chkCnt_q <= 16'h0000;
                else
                    chkCnt_q <= chkCnt_q + 16'h0001;
            end
        end
    end

    // ****************************************
    // Mode sequencer and control register
    // ****************************************
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q    <= ST_RST;
            ctrl_q     <= `CRG_CTL_RESET;
            rstCnt_q   <= 8'h00;
            stepCnt_q  <= 2'h0;
            resetCause <= 2'h1;
            pendRst_q  <= 1'b0;
        end else if (extLvl_q | watchdogExpire) begin
            // Defaults restored at once, reset sequence restarts
            state_q    <= ST_RST;
            ctrl_q     <= `CRG_CTL_RESET;
            rstCnt_q   <= 8'h00;
            resetCause <= extLvl_q ? 2'h1 : 2'h2;
        end else if (lossEvt & ~ctrl_q[`CRG_CTL_SELF_CLOCK_MODE_ENABLE]) begin
            state_q    <= ST_RST;
            ctrl_q     <= `CRG_CTL_RESET;
            rstCnt_q   <= 8'h00;
            resetCause <= 2'h3;
        end else begin
            if (accept & avs_write & avs_address == `CRG_OFS_CTRL & state_q == ST_RUN)
                ctrl_q <= avs_writedata[6:0];
            case (state_q)
                ST_RST: begin
                    rstCnt_q <= rstCnt_q + 8'h01;
                    if (rstCnt_q == RST_LEN) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (stopReq) begin
                        state_q   <= ST_DSEL;
                        stepCnt_q <= 2'h0;
                        ctrl_q[`CRG_CTL_PLL_CLOCK_SELECT] <= 1'b0;
                    end else if (waitReq) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Unmasked own event with irq enable, or other irq
                    if (irqPending | (lossEvt & ctrl_q[`CRG_CTL_SELF_CLOCK_IRQ_ENABLE]) |
                        (irq & ~(status_q[`CRG_ST_SELF_CLOCK_IRQ_FLAG] & ~ctrl_q[`CRG_CTL_SELF_CLOCK_IRQ_ENABLE]))) begin
                        state_q <= ST_RUN;
                        if (pllPowerDown & ~selfClockMode)
                            ctrl_q[`CRG_CTL_PLL_CLOCK_SELECT] <= 1'b0;
                    end
                end
                ST_DSEL, ST_PLLO, ST_CORO: begin
                    stepCnt_q <= stepCnt_q + 2'h1;
                    if (stepCnt_q == `CRG_STEP_CYC) begin
                        stepCnt_q <= 2'h0;
                        state_q   <= {state_q[5:0], 1'b0};
                    end
                end
                ST_STOP: begin
                    if (irqPending | irq)
                        state_q <= ST_RUN;
                end
                default: state_q <= ST_RST;
            endcase
        end
    end

    // ****************************************
    // Clock and power outputs
    // ****************************************
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            resetOut      <= 1'b1;
            coreClkEn     <= 1'b0;
            sysClkEn      <= 1'b0;
            pllEnable     <= 1'b0;
            oscEnable     <= 1'b1;
            vregLowPower  <= 1'b0;
            rtiClkEn      <= 1'b0;
            watchdogClkEn <= 1'b0;
            runMode       <= 1'b0;
        end else begin
            resetOut  <= (state_q == ST_RST);
            runMode   <= (state_q == ST_RUN);
            coreClkEn <= (state_q == ST_RUN) | (state_q == ST_DSEL) | (state_q == ST_PLLO);
            sysClkEn  <= ~inStop;
            // Self-clock keeps PLL up through wait and pseudo stop
            pllEnable <= ctrl_q[`CRG_CTL_PLL_CLOCK_SELECT] |
                         (selfClockMode & ~(inStop & ~pseudo)) |
                         (state_q == ST_DSEL);
            oscEnable    <= ~inStop | pseudo;
            vregLowPower <= inStop & ~(selfClockMode & pseudo);
            rtiClkEn     <= ~inStop | (pseudo & ctrl_q[`CRG_CTL_PRE]);
            watchdogClkEn <= ~inStop | (pseudo & ctrl_q[`CRG_CTL_PCE]);
        end
    end
endmodule // crg_lp_ctrl

`default_nettype wire

// file: crg_lp_monitor.sv
// Port-level checks of the low-power clock generator
`timescale 1ns/1ps
`default_nettype none
module crg_lp_monitor #(
    parameter CHECK_CYC = 2000 // Quality window, kept in step with the design
) (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       extResetReq,
    input wire logic       watchdogExpire,
    input wire logic       stopReq,
    input wire logic       irqPending,
    input wire logic       runMode,
    input wire logic       resetOut,
    input wire logic [1:0] resetCause,
    input wire logic       coreClkEn,
    input wire logic       sysClkEn,
    input wire logic       pllEnable,
    input wire logic       oscEnable,
    input wire logic       vregLowPower,
    input wire logic       selfClockMode
);
    // ****************************************
    // Properties, all in the system clock domain
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Pin sync takes three or four cycles
    property p_ext_reset;
        $rose(extResetReq) |-> ##[1:8] (resetOut && resetCause == 2'h1);
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("pin reset missing");
    property p_wdog_reset;
        watchdogExpire && !resetOut |-> ##[1:4] (resetOut && resetCause == 2'h2);
    endproperty
    a_wdog_reset: assert property (p_wdog_reset) else $error("watchdog reset missing");
    property p_run_after;
        $fell(resetOut) |-> runMode && sysClkEn;
    endproperty
    a_run_after: assert property (p_run_after) else $error("no run after reset");
    property p_mon_reset;
        $changed(resetCause) && resetCause == 2'h3 |=> resetOut;
    endproperty
    a_mon_reset: assert property (p_mon_reset) else $error("monitor cause without reset");
    // Stop wake returns to run without waiting on the oscillator; the bound is loose
    property p_irq_wake;
        irqPending && !runMode && !resetOut && !coreClkEn |-> ##[1:200] (runMode && !resetOut);
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("interrupt did not wake");
    property p_stop_order;
        $fell(sysClkEn) && !selfClockMode |-> !coreClkEn && !pllEnable;
    endproperty
    a_stop_order: assert property (p_stop_order) else $error("stop gating order");
    property p_stop_time;
        runMode && stopReq |-> ##[1:16] !sysClkEn;
    endproperty
    a_stop_time: assert property (p_stop_time) else $error("stop never became active");
    property p_stop_voltage_regulator;
        $fell(sysClkEn) && !selfClockMode |-> ##[0:4] vregLowPower;
    endproperty
    a_stop_voltage_regulator: assert property (p_stop_voltage_regulator) else $error("regulator not asked to save power");
    property p_osc_off;
        !oscEnable |-> !sysClkEn && !coreClkEn;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator off while clocked");
    // Halted on self clock with oscillator kept: PLL and regulator stay up
    property p_scm_keep;
        selfClockMode && !coreClkEn && oscEnable && $past(selfClockMode) |-> pllEnable && !vregLowPower;
    endproperty
    a_scm_keep: assert property (p_scm_keep) else $error("self clock lost PLL or regulator");
endmodule // crg_lp_monitor
bind crg_lp_ctrl crg_lp_monitor #(.CHECK_CYC(CHECK_CYC)) crg_lp_monitor_i (
    .clk_sys, .resetn, .extResetReq, .watchdogExpire, .stopReq, .irqPending, .runMode,
    .resetOut, .resetCause, .coreClkEn, .sysClkEn, .pllEnable, .oscEnable, .vregLowPower,
    .selfClockMode
);
`default_nettype wire

// file: crg_core_model.sv
// Processor core model: wait, stop, interrupt and watchdog requests
`timescale 1ns/1ps
`default_nettype none
module crg_core_model (
    input  wire logic       clk_sys,        // System clock
    input  wire logic       resetn,         // Async reset, active low
    input  wire logic       runMode,        // Core running
    input  wire logic [3:0] cmd,            // Pulses: wait, stop, irq, watchdog
    output var  logic       waitReq,        // Held until the core halts
    output var  logic       stopReq,        // Held until the core halts
    output var  logic       irqPending,     // Held until the core runs
    output var  logic       watchdogExpire  // One-cycle timeout
);
    // ****************************************
    // Request hold
    // ****************************************
    // A halt instruction stays pending until the core leaves run mode
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            waitReq <= 1'h0;
            stopReq <= 1'h0;
            irqPending <= 1'h0;
            watchdogExpire <= 1'h0;
        end else begin
            waitReq <= cmd[0] | (waitReq & runMode);
            stopReq <= cmd[1] | (stopReq & runMode);
            irqPending <= cmd[2] | (irqPending & ~runMode); // Serviced once running
            watchdogExpire <= cmd[3];
        end
    end
endmodule // crg_core_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the low-power clock generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_sys, resetn, extResetReq, oscClockLost, oscClockGood, pllPowerDown;
    logic        avs_read, avs_write, avs_waitrequest, irq, resetOut, runMode;
    logic [3:0]  avs_address, cmd;
    logic [31:0] avs_writedata, avs_readdata, rq;
    logic [1:0]  resetCause;
    logic        coreClkEn, sysClkEn, pllEnable, oscEnable, vregLowPower, rtiClkEn, watchdogClkEn;
    logic        selfClockMode, waitReq, stopReq, irqPending, watchdogExpire;
    int          n_fail = 0;
    int          n_tests = 0;
    wire [7:0]   obs = {selfClockMode, irq, vregLowPower, oscEnable, sysClkEn, coreClkEn, resetOut, runMode};
    localparam int RUN = 0, RST = 1, SYS = 3, IRQ = 6, SELF_CLOCK_MODE = 7; // Bit of obs
    crg_lp_ctrl #(.CHECK_CYC(20)) crg_lp_ctrl_i (.clk_sys, .resetn, .extResetReq, .watchdogExpire,
        .oscClockLost, .oscClockGood, .waitReq, .stopReq, .irqPending, .pllPowerDown, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .resetOut,
        .resetCause, .coreClkEn, .sysClkEn, .pllEnable, .oscEnable, .vregLowPower, .rtiClkEn,
        .watchdogClkEn, .selfClockMode, .runMode);
    crg_core_model crg_core_model_i (.clk_sys, .resetn, .runMode, .cmd, .waitReq, .stopReq,
        .irqPending, .watchdogExpire);
    // ****************************************
    // Shared tasks
    // ****************************************
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Avalon access; request held until waitrequest is seen low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'h0 && k < 50);
        rq = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk_sys); // Avoids a double drive at the next request
        if (k >= 50) n_fail++;
        if (k >= 50) give_verdict();
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(1'h0, a, 32'h0);
        chk(nm, rq, e);
    endtask
    task core(input int c);
        cmd <= 4'h1 << c;
        @(posedge clk_sys);
        cmd <= 4'h0;
    endtask
    // Bounded wait; running out ends the run
    task wait_for(input int s, input logic v, input int lim);
        int k;
        for (k = 0; k < lim && obs[s] !== v; k++) @(posedge clk_sys);
        chk("wait", obs[s], v);
        if (obs[s] !== v) give_verdict();
    endtask
    task restart;
        resetn <= 1'h0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'h1;
        wait_for(RUN, 1'h1, 200);
        @(posedge clk_sys); // Reset flag falls in the same cycle that run rises
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task s_rti;
        bus(1'h1, 4'hC, 32'h00); // Prescale 1000, count 0
        bus(1'h1, 4'h8, 32'h02);
        bus(1'h1, 4'h4, 32'h0F);
        wait_for(IRQ, 1'h1, 1100);
        bus(1'h1, 4'h4, 32'h02);
        repeat (980) @(posedge clk_sys);
        chk("early tick", irq, 32'h0);
        wait_for(IRQ, 1'h1, 30);
        bus(1'h1, 4'h8, 32'h00);
        @(posedge clk_sys);
        chk("masked irq", irq, 32'h0);
    endtask
    task s_regs;
        rd(4'h0, 32'h03, "ctrl");
        rd(4'h2, 32'h00, "unmapped");
        bus(1'h1, 4'hC, 32'hFF);
        rd(4'hC, 32'h7F, "rate");
    endtask
    task s_wait_pll;
        bus(1'h1, 4'h0, 32'h0B);
        pllPowerDown <= 1'h1;
        core(0);
        wait_for(RUN, 1'h0, 20);
        repeat (30) @(posedge clk_sys);
        chk("no cause wake", runMode, 32'h0);
        core(2);
        wait_for(RUN, 1'h1, 60);
        chk("no reset", resetOut, 32'h0);
        pllPowerDown <= 1'h0;
        rd(4'h0, 32'h03, "pll select");
        bus(1'h1, 4'h0, 32'h0B);
        rd(4'h0, 32'h0B, "reselect");
    endtask
    // Expected gates: oscillator, timer, watchdog
    task s_stop(input logic [31:0] ctl, input logic [2:0] e);
        bus(1'h1, 4'h0, ctl);
        core(1);
        wait_for(SYS, 1'h0, 40);
        repeat (4) @(posedge clk_sys);
        chk("pll off", pllEnable, 32'h0);
        chk("voltage_regulator", vregLowPower, 32'h1);
        chk("stop gates", {28'h0, coreClkEn, oscEnable, rtiClkEn, watchdogClkEn}, {29'h0, e});
        core(2);
        wait_for(RUN, 1'h1, 200);
        rd(4'h0, ctl & 32'hF7, "select cleared");
    endtask
    task s_wdog;
        bus(1'h1, 4'h0, 32'h00);
        core(0);
        wait_for(RUN, 1'h0, 20);
        core(3);
        wait_for(RST, 1'h1, 10);
        chk("wdog cause", resetCause, 32'h2);
        wait_for(RUN, 1'h1, 200);
        @(posedge clk_sys);
        rd(4'h0, 32'h03, "defaults");
    endtask
    // Pin reset, or monitor loss without self-clock
    task s_pin(input logic mon);
        bus(1'h1, 4'h0, {31'h0, mon});
        extResetReq <= ~mon;
        oscClockLost <= mon;
        wait_for(RST, 1'h1, 10);
        chk("reset cause", resetCause, mon ? 32'h3 : 32'h1);
        extResetReq <= 1'h0;
        oscClockLost <= 1'h0;
        wait_for(RUN, 1'h1, 200);
        @(posedge clk_sys);
    endtask
    task s_scm(input logic ie);
        bus(1'h1, 4'h8, {31'h0, ie});
        bus(1'h1, 4'h0, {29'h0, ie, 2'h3});
        core(0);
        wait_for(RUN, 1'h0, 20);
        oscClockLost <= 1'h1;
        wait_for(SELF_CLOCK_MODE, 1'h1, 10);
        repeat (10) @(posedge clk_sys);
        chk("scm wake", runMode, {31'h0, ie});
        chk("scm irq", irq, {31'h0, ie});
        bus(1'h0, 4'h4, 32'h0);
        chk("scm flag", rq & 32'h1, 32'h1);
        oscClockLost <= 1'h0;
        core(2);
        wait_for(RUN, 1'h1, 200);
        restart;
    endtask
    // ****************************************
    // Clock and main sequence
    // ****************************************
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {resetn, extResetReq, oscClockLost, pllPowerDown, avs_read, avs_write} = 6'h00;
        oscClockGood = 1'h1;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        cmd = 4'h0;
        restart;
        s_rti;
        s_regs;
        s_wait_pll;
        s_stop(32'h0B, 3'h0);
        s_stop(32'h3B, 3'h0);
        s_stop(32'h43, 3'h4);
        s_stop(32'h63, 3'h6);
        s_stop(32'h53, 3'h5);
        s_wdog;
        s_pin(1'h0);
        s_pin(1'h1);
        s_scm(1'h1);
        s_scm(1'h0);
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
